// >>> rsc_defs.svh
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
`define RSC_CLK_HZ 125000000
`define RSC_BASE_HZ 2000000
`define RSC_STEP_HZ 40000
`define RSC_SS_TIME_US 1400
`define RSC_SS_CYC (`RSC_SS_TIME_US * (`RSC_CLK_HZ / 1000000))
`define RSC_HICCUP_HZ 32000
`define RSC_HICCUP_CYC (`RSC_CLK_HZ / `RSC_HICCUP_HZ)
`define RSC_MIN_OFF_CYC 4
`define RSC_DUTY90 8'hE7
`define RSC_DUTY_FULL 8'hFF
`define RSC_OVER_MAX 2'h3
`define RSC_SYNC_LOSS 8'h7D
`define RSC_LFSR_SEED 4'h1
`define RSC_ADDR_CTRL 32'h0000_0000
`define RSC_ADDR_STATUS 32'h0000_0004
`define RSC_ADDR_BIN 32'h0000_0008
`define RSC_CTRL_RST 2'h3
`define RSC_CTRL_SPREAD 0
`define RSC_CTRL_SYNC 1
`endif

// >>> rsc_pkg.sv
`default_nettype none
package rsc_pkg;
    typedef enum logic [2:0] {
        RSC_SHUT = 3'b001,
        RSC_START = 3'b010,
        RSC_RUN = 3'b100
    } rsc_seq_t;
    typedef enum logic [3:0] {
        RSC_OFF = 4'b0001,
        RSC_SOFT = 4'b0010,
        RSC_ON = 4'b0100,
        RSC_HICC = 4'b1000
    } rsc_mode_t;
    // Analog status of one converter, valid every clock.
    typedef struct packed {
        logic ilim;
        logic overload;
        logic [7:0] duty;
    } rsc_rail_in_t;
    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] lfsr;
        logic start;
    } rsc_osc_t;
    typedef struct packed {
        rsc_mode_t mode;
        logic [17:0] tmr;
        logic [8:0] pcnt;
        logic phase;
        logic off_done;
        logic [1:0] over_cnt;
        logic gate;
    } rsc_rail_t;
    typedef struct packed {
        rsc_seq_t seq;
        logic [1:0] ctrl;
        logic high_supply_shutdown;
        logic hv;
        logic sync_prev;
        logic sync_locked;
        logic [7:0] loss;
        logic [3:0] gate;
        logic [3:0] ss;
        logic [1:0] fault_oe_n;
        logic [1:0] fault_lvl;
        logic [31:0] hrdata;
        logic hreadyout;
        logic resp;
        logic [1:0] w_sel;
    } rsc_top_t;
endpackage : rsc_pkg
`default_nettype wire

// >>> rsc_osc.sv
`include "rsc_defs.svh"
`default_nettype none
module rsc_osc (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spread_en,
    input wire logic fold,
    input wire logic sync_pulse,
    output logic period_start,
    output logic [7:0] period_len,
    output logic [3:0] bin
);
    import rsc_pkg::*;
    rsc_osc_t st;
    rsc_osc_t next_st;
    logic [7:0] tbl [16];

    // Adding the nor term inserts the all-zero state, so all sixteen bins
    // occur once per cycle of the sequence.
    function automatic logic [3:0] rsc_lfsr_next(input logic [3:0] s);
        return {s[2:0], s[3] ^ s[0] ^ (s[2:0] == 3'b000)};
    endfunction : rsc_lfsr_next

    for (genvar g = 0; g < 16; g++) begin : g_bin
        assign tbl[g] = 8'(`RSC_CLK_HZ /
            (`RSC_BASE_HZ + g * `RSC_STEP_HZ));
    end

    assign period_len = fold ? {tbl[st.lfsr][6:0], 1'b0} : tbl[st.lfsr];
    assign period_start = st.start;
    assign bin = st.lfsr;

    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        if (sync_pulse || st.cnt >= period_len - 8'h01) begin
            next_st.cnt = 8'h00;
            next_st.start = 1'b1;
            next_st.lfsr = rsc_lfsr_next(st.lfsr);
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
        if (!spread_en) begin
            next_st.lfsr = 4'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.lfsr <= `RSC_LFSR_SEED;
        end else begin
            st <= next_st;
        end
    end
endmodule : rsc_osc
`default_nettype wire

// >>> rsc_rail.sv
`include "rsc_defs.svh"
`default_nettype none
module rsc_rail #(
    parameter int SS_CYC = `RSC_SS_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic block,
    input wire logic half,
    input wire logic period_start,
    input wire logic [7:0] period_len,
    input wire rsc_pkg::rsc_rail_in_t ain,
    output logic gate,
    output logic ss_run,
    output logic ready,
    output logic hiccup
);
    import rsc_pkg::*;
    rsc_rail_t st;
    rsc_rail_t next_st;
    logic [8:0] eff;
    logic [16:0] prod;
    logic [8:0] on_cyc;
    logic start;
    logic cut;

    assign gate = st.gate;
    assign ss_run = st.mode == RSC_SOFT;
    assign ready = st.mode == RSC_ON;
    assign hiccup = st.mode == RSC_HICC;

    always_comb begin
        next_st = st;
        eff = half ? {period_len, 1'b0} : {1'b0, period_len};
        prod = 17'(eff * ain.duty);
        on_cyc = (ain.duty == `RSC_DUTY_FULL) ? eff : prod[16:8];
        start = period_start && (!half || st.phase);
        cut = ain.ilim || st.pcnt >= on_cyc ||
            (st.over_cnt == `RSC_OVER_MAX &&
            st.pcnt >= eff - 9'(`RSC_MIN_OFF_CYC));
        if (period_start) begin
            next_st.phase = ~st.phase;
        end
        if (start) begin
            next_st.pcnt = 9'h000;
            next_st.off_done = 1'b0;
            next_st.over_cnt = (ain.duty >= `RSC_DUTY90 &&
                st.over_cnt != `RSC_OVER_MAX) ?
                st.over_cnt + 2'h1 : 2'h0;
        end else begin
            if (st.pcnt != 9'h1FF) begin
                next_st.pcnt = st.pcnt + 9'h001;
            end
            if (cut) begin
                next_st.off_done = 1'b1;
            end
        end
        case (st.mode)
            RSC_OFF: begin
                next_st.mode = RSC_SOFT;
                next_st.tmr = 18'h00000;
            end
            RSC_SOFT: begin
                next_st.tmr = st.tmr + 18'h00001;
                if (ain.overload) begin
                    next_st.mode = RSC_HICC;
                    next_st.tmr = 18'h00000;
                end else if (st.tmr == 18'(SS_CYC - 1)) begin
                    next_st.mode = RSC_ON;
                end
            end
            RSC_ON: begin
                if (ain.overload) begin
                    next_st.mode = RSC_HICC;
                    next_st.tmr = 18'h00000;
                end
            end
            RSC_HICC: begin
                next_st.tmr = st.tmr + 18'h00001;
                if (st.tmr == 18'(`RSC_HICCUP_CYC - 1)) begin
                    next_st.mode = RSC_SOFT;
                    next_st.tmr = 18'h00000;
                end
            end
            default: next_st.mode = RSC_OFF;
        endcase
        if (!en) begin
            next_st.mode = RSC_OFF;
            next_st.tmr = 18'h00000;
        end
        // Switch-on happens only at a period start once turned off.
        next_st.gate = en && !block && !next_st.off_done &&
            (st.mode == RSC_SOFT || st.mode == RSC_ON) &&
            (start || st.gate);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.mode <= RSC_OFF;
        end else begin
            st <= next_st;
        end
    end

    a_gate_rise: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(st.gate) |-> $past(start))
        else $error("Switch turned on away from a period start.");
    a_ilim_cut: assert property (@(posedge ref_clk) disable iff (rst)
        ain.ilim && !start |=> !st.gate ##1 (!st.gate || $past(start)))
        else $error("Current limit did not end the on time.");
    a_max_duty: assert property (@(posedge ref_clk) disable iff (rst)
        st.over_cnt == 2'h3 && st.pcnt >= eff - 9'h004 && !start
        |=> !st.gate)
        else $error("Minimum off time not forced in fourth period.");
endmodule : rsc_rail
`default_nettype wire

// >>> rsc_top.sv
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Supply lockout stops all switching and returns every soft-start to idle.
// - Overvoltage stops switching; release only once supply falls below 34 V.
// - Global on low means shutdown: all outputs stopped, no activity.
// - Global on high starts primary rail soft-start, about 1.4 ms.
// - Boost rail soft-start follows primary completion, enabled by global on.
// - Each secondary buck runs its own soft-start when its enable is high.
// - Secondary bucks stay disabled until primary soft-start has completed.
// - One shared oscillator clocks all four rails; sync retimes them all.
// - Duty and high-voltage foldback act per rail, not on the oscillator.
// - After switch-off, switch-on waits for the next period start.
// - Over 90% duty for three periods forces off time in the fourth.
// - Primary rail halves frequency above 20 V, restores below 18 V.
// - Spread spectrum picks a 4-bit bin, each adding 40 kHz.
// - The bin sequence visits all sixteen bins equally often.
// - On and off times scale with period so duty stays constant.
// - Peak current trip ends the on time until the next period.
// - Severe primary overload lowers the shared oscillator frequency.
// - Persistent overload: off for the hiccup interval, then restart.
// - Spread spectrum is off while locked to external sync.
// - Sync rising edge restarts the period; ignored outside normal running.
// - Secondary fault outputs are held low while their rail is disabled.
//////////////////////////////////////////////////////////////////////////////
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`include "rsc_defs.svh"
`default_nettype none
module rsc_top #(
    parameter int SS_CYC = `RSC_SS_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic global_on_input,
    input wire logic rail2_on_input,
    input wire logic rail3_on_input,
    input wire logic ext_sync_input,
    input wire logic low_supply_lockout,
    input wire logic supply_over_high,
    input wire logic supply_below_release,
    input wire logic vin_above_upper,
    input wire logic vin_below_lower,
    input wire logic primary_severe_overload,
    input wire rsc_pkg::rsc_rail_in_t [3:0] rail_in,
    input wire logic [1:0] rail_fault_in,
    output logic [1:0] rail_fault_out,
    output logic [1:0] rail_fault_oe_n,
    output logic [3:0] gate_out,
    output logic [3:0] ss_run_out
);
    import rsc_pkg::*;
    rsc_top_t st;
    rsc_top_t next_st;
    logic run_ok;
    logic sync_edge;
    logic sync_take;
    logic spread_en;
    logic [3:0] rail_en;
    logic [3:0] r_gate;
    logic [3:0] r_ss;
    logic [3:0] r_ready;
    logic [3:0] r_hiccup;
    logic osc_start;
    logic [7:0] osc_len;
    logic [3:0] osc_bin;
    logic a_phase;
    logic [1:0] a_sel;

    // Only the aligned word addresses 0, 4 and 8 in the low page are mapped; hsize is not decoded.
    function automatic logic [1:0] rsc_decode(input logic [31:0] a);
        case (a)
            `RSC_ADDR_CTRL: return 2'h1;
            `RSC_ADDR_STATUS: return 2'h2;
            `RSC_ADDR_BIN: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction : rsc_decode

    assign hrdata = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp = st.resp;
    assign gate_out = st.gate;
    assign ss_run_out = st.ss;
    assign rail_fault_out = st.fault_lvl;
    assign rail_fault_oe_n = st.fault_oe_n;

    //////////////////////////////////////////////////////////////////////////
    rsc_osc u_osc (
        .ref_clk(ref_clk),
        .rst(rst),
        .spread_en(spread_en),
        .fold(primary_severe_overload),
        .sync_pulse(sync_take),
        .period_start(osc_start),
        .period_len(osc_len),
        .bin(osc_bin)
    );

    // Index 0 is the primary buck, 1 and 2 the secondary bucks, 3 the boost.
    for (genvar i = 0; i < 4; i++) begin : g_rail
        rsc_rail #(
            .SS_CYC(SS_CYC)
        ) u_rail (
            .ref_clk(ref_clk),
            .rst(rst),
            .en(rail_en[i]),
            .block(st.high_supply_shutdown),
            .half((i == 0) && st.hv),
            .period_start(osc_start),
            .period_len(osc_len),
            .ain(rail_in[i]),
            .gate(r_gate[i]),
            .ss_run(r_ss[i]),
            .ready(r_ready[i]),
            .hiccup(r_hiccup[i])
        );
    end

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        run_ok = global_on_input && !low_supply_lockout;
        rail_en[0] = run_ok && st.seq != RSC_SHUT;
        rail_en[3] = run_ok && st.seq == RSC_RUN && r_ready[0];
        rail_en[1] = rail_en[3] && rail2_on_input;
        rail_en[2] = rail_en[3] && rail3_on_input;
        case (st.seq)
            RSC_SHUT: begin
                next_st.seq = RSC_START;
            end
            RSC_START: begin
                if (r_ready[0]) begin
                    next_st.seq = RSC_RUN;
                end
            end
            RSC_RUN: begin
                if (!r_ready[0]) begin
                    next_st.seq = RSC_START;
                end
            end
            default: next_st.seq = RSC_SHUT;
        endcase
        if (!run_ok) begin
            next_st.seq = RSC_SHUT;
        end
        // Setting dominates so a rising supply is never missed.
        if (supply_over_high) begin
            next_st.high_supply_shutdown = 1'b1;
        end else if (supply_below_release) begin
            next_st.high_supply_shutdown = 1'b0;
        end
        if (vin_above_upper) begin
            next_st.hv = 1'b1;
        end else if (vin_below_lower) begin
            next_st.hv = 1'b0;
        end
        next_st.sync_prev = ext_sync_input;
        sync_edge = ext_sync_input && !st.sync_prev;
        sync_take = sync_edge && st.seq == RSC_RUN && !st.high_supply_shutdown &&
            st.ctrl[`RSC_CTRL_SYNC];
        if (sync_take) begin
            next_st.sync_locked = 1'b1;
            next_st.loss = 8'h00;
        end else if (st.sync_locked) begin
            next_st.loss = st.loss + 8'h01;
            // A stopped sync clock falls back to the free-running rate.
            if (st.loss == `RSC_SYNC_LOSS) begin
                next_st.sync_locked = 1'b0;
            end
        end
        if (st.seq != RSC_RUN || st.high_supply_shutdown) begin
            next_st.sync_locked = 1'b0;
        end
        spread_en = st.ctrl[`RSC_CTRL_SPREAD] && !st.sync_locked;
        next_st.gate = r_gate;
        next_st.ss = r_ss;
        next_st.fault_lvl = 2'h0;
        next_st.fault_oe_n = r_ready[2:1] & {2{!st.high_supply_shutdown}};
        next_st.hreadyout = 1'b1;
        next_st.resp = 1'b0;
        a_phase = hsel && htrans[1] && hready;
        a_sel = rsc_decode(haddr);
        if (st.w_sel == 2'h1) begin
            next_st.ctrl = hwdata[1:0];
        end
        next_st.w_sel = (a_phase && hwrite) ? a_sel : 2'h0;
        if (a_phase && !hwrite) begin
            case (a_sel)
                2'h1: next_st.hrdata = {30'h0000_0000, st.ctrl};
                2'h2: next_st.hrdata = {16'h0000, rail_fault_in, st.hv,
                    st.high_supply_shutdown, st.sync_locked, st.seq, r_hiccup, r_ready};
                2'h3: next_st.hrdata = {28'h000_0000, osc_bin};
                default: next_st.hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.seq <= RSC_SHUT;
            st.ctrl <= `RSC_CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_low_supply_lockout_gates: assert property (
        low_supply_lockout |-> ##2 gate_out == 4'h0)
        else $error("Gate on during supply lockout.");
    a_low_supply_lockout_ss_reset: assert property (
        low_supply_lockout |=> r_ready == 4'h0 && r_ss == 4'h0)
        else $error("Soft-start not reset by lockout.");
    a_high_supply_shutdown_gates: assert property (
        st.high_supply_shutdown |-> ##2 gate_out == 4'h0)
        else $error("Gate on during overvoltage.");
    a_high_supply_shutdown_hold: assert property (
        st.high_supply_shutdown && !supply_below_release |=> st.high_supply_shutdown)
        else $error("Overvoltage released too early.");
    a_shutdown_all: assert property (
        !global_on_input |-> ##2 gate_out == 4'h0 && ss_run_out == 4'h0)
        else $error("Activity while globally off.");
    a_primary_start: assert property (
        run_ok && st.seq == RSC_START && $past(st.seq) == RSC_SHUT
        |-> ##2 ss_run_out[0])
        else $error("Primary soft-start did not begin.");
    a_boost_after: assert property (
        $rose(ss_run_out[3]) |-> $past(r_ready[0], 2))
        else $error("Boost started before primary completed.");
    a_rail2_gate: assert property (
        $rose(ss_run_out[1]) |-> $past(r_ready[0] && rail2_on_input, 2))
        else $error("Secondary rail started without permission.");
    a_fault_low: assert property (
        !rail_en[1] |-> ##2 !rail_fault_oe_n[0] && !rail_fault_out[0])
        else $error("Fault output released on a disabled rail.");
    a_sync_restart: assert property (
        sync_take |=> osc_start)
        else $error("Sync edge did not restart the period.");
    a_sync_ignored: assert property (
        st.seq != RSC_RUN |=> !st.sync_locked)
        else $error("Sync locked outside normal running.");
    a_sync_spread: assert property (
        st.sync_locked |=> osc_bin == 4'h0)
        else $error("Spread spectrum active while synced.");
    a_hv_hold: assert property (
        st.hv && !vin_below_lower |=> st.hv)
        else $error("High-voltage foldback left too early.");

    c_boost_start: cover property ($rose(ss_run_out[3]));
    c_sync_lock: cover property ($rose(st.sync_locked));
    c_hiccup: cover property ($rose(r_hiccup[0]));
    c_half_freq: cover property (st.hv && r_ready[0]);
endmodule : rsc_top
`default_nettype wire

// >>> rsc_conv_model.sv
`default_nettype none
module rsc_conv_model (
    input wire logic ref_clk,
    input wire logic [3:0] gate,
    input wire logic [3:0] ovl,
    input wire logic trip_en,
    input wire logic [7:0] duty,
    input wire logic [1:0] fault_oe_n,
    output rsc_pkg::rsc_rail_in_t [3:0] rail_in,
    output logic [1:0] fault_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsc_pkg::*;
    int on_t [4];
    // The fault pins are open drain with a pull-up, so released reads high.
    assign fault_lvl = fault_oe_n;
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 4; i++) begin
            on_t[i] <= gate[i] ? on_t[i] + 1 : 0;
        end
    end
    // The trip comes late in the on time, as a real inductor ramp would.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rail_in[i].ilim = trip_en && (on_t[i] >= 20);
            rail_in[i].overload = ovl[i];
            rail_in[i].duty = duty;
        end
    end
endmodule : rsc_conv_model
`default_nettype wire

// >>> rail_sequencer_switch_clock_tb_top.sv
`default_nettype none
module rail_sequencer_switch_clock_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsc_pkg::*;
    localparam int SS = 200;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
    logic on = 1'b0, r2 = 1'b0, sync = 1'b0, uv = 1'b0, ov = 1'b0;
    logic rel = 1'b0, vhi = 1'b0, vlo = 1'b1, sev = 1'b0, trip = 1'b0;
    logic [3:0] ovl = 4'h0, gate_out, ss_run_out;
    logic [7:0] duty = 8'h80;
    logic [1:0] fo, foe_n, flvl;
    rsc_rail_in_t [3:0] rin;
    logic [31:0] seed = 32'hD6A0;
    int failures = 0, cmp_count = 0, n, mctrl;
    logic [15:0] seen;
    always #4 ref_clk = ~ref_clk;
    rsc_top #(.SS_CYC(SS)) rsc_top_i (.ref_clk(ref_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .global_on_input(on),
        .rail2_on_input(r2), .rail3_on_input(flvl[0]),
        .ext_sync_input(sync), .low_supply_lockout(uv),
        .supply_over_high(ov), .supply_below_release(rel),
        .vin_above_upper(vhi), .vin_below_lower(vlo),
        .primary_severe_overload(sev), .rail_in(rin),
        .rail_fault_in(flvl), .rail_fault_out(fo),
        .rail_fault_oe_n(foe_n), .gate_out(gate_out),
        .ss_run_out(ss_run_out));
    rsc_conv_model rsc_conv_model_i (.ref_clk(ref_clk), .gate(gate_out),
        .ovl(ovl), .trip_en(trip), .duty(duty), .fault_oe_n(foe_n),
        .rail_in(rin), .fault_lvl(flvl));
    //////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic summarize();
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask : cyc
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do begin @(posedge ref_clk); k++; end while (hready !== 1'b1 && k < 20);
        if (hready !== 1'b1) begin
            failures++;
            summarize();
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge ref_clk); k++; end while (hready !== 1'b1 && k < 40);
        q = hrdata;
        if (k > 30) begin
            failures++;
            summarize();
        end
    endtask : ahb
    // Waits for one soft-start flag, bounded; cnt gives the cycles spent.
    task automatic wss(input int i, input logic v, input int lim,
                       output int cnt);
        cnt = 0;
        while (ss_run_out[i] !== v && cnt < lim) begin
            @(posedge ref_clk);
            cnt++;
        end
        if (cnt >= lim) begin
            failures++;
            summarize();
        end
    endtask : wss
    //////////////////////////////////////////////////////////////////////
    initial begin
        cyc(16);
        rst <= 1'b0;
        cyc(2);
        chk(gate_out, 4'h0);
        chk({hready, hresp, fo}, 4'h8);
        ahb(0, 32'h0, 0, st); chk(st, 32'h3);
        ahb(0, 32'h4, 0, st); chk(st[10:8], 3'b001);
        ahb(0, 32'hC, 0, st); chk(st, 32'h0);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            mctrl = seed[1:0];
            ahb(1, 32'h0, seed, st);
            ahb(0, 32'h0, 0, st); chk(st, mctrl);
        end
        ahb(1, 32'h0, 32'h3, st);
        seed = xs(seed);
        duty <= 8'h40 + {1'b0, seed[6:0]};
        rel <= 1'b1;
        on <= 1'b1;
        r2 <= 1'b1;
        wss(0, 1'b1, 20, n);
        chk(ss_run_out[2:1], 2'h0);
        chk(foe_n[1], 1'b0);
        wss(0, 1'b0, SS + 50, n);
        chk(n >= SS - 10 && n <= SS + 4, 1'b1);
        wss(3, 1'b1, 10, n);
        wss(1, 1'b1, 10, n);
        wss(1, 1'b0, SS + 20, n);
        wss(2, 1'b1, 20, n);
        ahb(0, 32'h4, 0, st); chk(st[10:8], 3'b100);
        seen = 16'h0;
        for (int k = 0; k < 200; k++) begin
            ahb(0, 32'h8, 0, st);
            seen[st[3:0]] = 1'b1;
            cyc(21);
        end
        chk(seen, 16'hFFFF);
        ahb(1, 32'h0, 32'h2, st);
        cyc(70);
        ahb(0, 32'h8, 0, st); chk(st, 32'h0);
        ahb(1, 32'h0, 32'h3, st);
        for (int k = 0; k < 10; k++) begin
            sync <= 1'b1;
            cyc(25);
            sync <= 1'b0;
            cyc(25);
        end
        ahb(0, 32'h4, 0, st); chk(st[11], 1'b1);
        ahb(0, 32'h8, 0, st); chk(st, 32'h0);
        cyc(200);
        ahb(0, 32'h4, 0, st); chk(st[11], 1'b0);
        vlo <= 1'b0;
        vhi <= 1'b1;
        cyc(3);
        ahb(0, 32'h4, 0, st); chk(st[13], 1'b1);
        vhi <= 1'b0;
        cyc(3);
        ahb(0, 32'h4, 0, st); chk(st[13], 1'b1);
        vlo <= 1'b1;
        cyc(3);
        ahb(0, 32'h4, 0, st); chk(st[13], 1'b0);
        trip <= 1'b1;
        n = 0;
        for (int k = 0, r = 0; k < 600; k++) begin
            @(posedge ref_clk);
            r = gate_out[0] ? r + 1 : 0;
            n = r > n ? r : n;
        end
        chk(n <= 24 && n > 0, 1'b1);
        trip <= 1'b0;
        duty <= 8'hFF;
        n = 0;
        for (int k = 0; k < 300; k++) begin
            @(posedge ref_clk);
            n += gate_out[3] ? 0 : 1;
        end
        chk(n > 0 && n < 150, 1'b1);
        duty <= 8'h80;
        ovl <= 4'h2;
        cyc(10);
        ahb(0, 32'h4, 0, st); chk(st[5], 1'b1);
        ovl <= 4'h0;
        n = 0;
        for (int k = 0; k < 3000; k++) begin
            @(posedge ref_clk);
            n += gate_out[1] ? 1 : 0;
        end
        chk(n, 0);
        cyc(SS + 1500);
        ahb(0, 32'h4, 0, st); chk(st[5], 1'b0);
        chk(st[1], 1'b1);
        ov <= 1'b1;
        rel <= 1'b0;
        cyc(3);
        ov <= 1'b0;
        cyc(5);
        chk(gate_out, 4'h0);
        ahb(0, 32'h4, 0, st); chk(st[12], 1'b1);
        rel <= 1'b1;
        cyc(5);
        ahb(0, 32'h4, 0, st); chk(st[12], 1'b0);
        uv <= 1'b1;
        cyc(4);
        chk({gate_out, ss_run_out}, 8'h0);
        uv <= 1'b0;
        on <= 1'b0;
        cyc(4);
        chk({gate_out, ss_run_out}, 8'h0);
        summarize();
    end
endmodule : rail_sequencer_switch_clock_tb_top
`default_nettype wire
